// ### rtl/global_sector_protect_decode.sv
// ------------------------------------------------------------
// Sector protection state with global protect and unprotect
// ------------------------------------------------------------
module global_sector_protect_decode (
    input  wire logic                                  clk,
    input  wire logic                                  sys_rst,
    // Command front end, one pulse per command at chip select end.
    input  wire logic                                  wsrDone,
    input  wire logic                                  wsrByteOk,
    input  wire logic [7:0]                            wsrData,
    input  wire logic                                  wrenDone,
    input  wire logic                                  wrdiDone,
    input  wire logic                                  sectorProtDone,
    input  wire logic                                  sectorUnprotDone,
    input  wire logic [flash_prot_pkg::SECTOR_IDX_W-1:0] sectorIdx,
    input  wire logic                                  wpN,
    output logic [flash_prot_pkg::SECTOR_COUNT-1:0]    protBits,
    output logic                                       protectionLockBit,
    output logic                                       writeEnableLatch,
    // APB slave.
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [flash_prot_pkg::APB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]                           pwdata,
    output logic [31:0]                                prdata,
    output logic                                       pready,
    output logic                                       pslverr
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0]              prot;
        logic                     lock;
        logic                     wrEn;
        logic                     cmdEn;
        flash_prot_pkg::outcome_t outcome;
        logic [31:0]              rdata;
        logic                     rdErr;
    } state_t;

    state_t stateQ;
    state_t stateD;

    logic [31:0]              decProt;
    logic                     decLock;
    flash_prot_pkg::outcome_t decOutcome;
    logic                     wsrGo;
    logic                     wsrDrop;
    logic                     secGo;
    logic                     secSeen;
    logic                     apbSetup;
    logic                     apbAccess;
    logic [31:0]              statusWord;

    wsr_decode decoder (
        .data     (wsrData),
        .lockCur  (stateQ.lock),
        .wpN      (wpN),
        .protCur  (stateQ.prot),
        .protNext (decProt),
        .lockNext (decLock),
        .outcome  (decOutcome)
    );

    // ------------------------------------------------------------
    // Command acceptance
    // ------------------------------------------------------------
    // A status write counts only when a whole byte arrived before chip
    // select ended and the write enable latch was already set.
    assign wsrGo   = wsrDone && wsrByteOk && stateQ.wrEn && stateQ.cmdEn;
    assign wsrDrop = wsrDone && !wsrGo;
    // The status write has priority; a sector command in the same cycle is lost.
    assign secSeen = !wsrDone && (sectorProtDone || sectorUnprotDone) && stateQ.cmdEn;
    assign secGo   = secSeen && stateQ.wrEn && !stateQ.lock;

    assign apbSetup  = psel && !penable;
    assign apbAccess = psel && penable;

    always_comb begin
        statusWord                                                 = '0;
        statusWord[flash_prot_pkg::ST_LOCK_POS]                    = stateQ.lock;
        statusWord[flash_prot_pkg::ST_WP_POS]                      = wpN;
        statusWord[flash_prot_pkg::ST_WREN_POS]                    = stateQ.wrEn;
        statusWord[flash_prot_pkg::ST_OUT_HI:flash_prot_pkg::ST_OUT_LO] = stateQ.outcome;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        stateD = stateQ;

        if (wsrGo) begin
            // Sectors and lock bit change in the same cycle.
            stateD.prot    = decProt;
            stateD.lock    = decLock;
            stateD.wrEn    = 1'b0;
            stateD.outcome = decOutcome;
        end else if (wsrDrop) begin
            stateD.outcome = flash_prot_pkg::OUT_DISCARDED;
        end else if (secSeen) begin
            stateD.wrEn = 1'b0;
            if (secGo) begin
                // Only the addressed sector moves.
                stateD.prot[sectorIdx] = sectorProtDone;
            end
        end else if (wrenDone && stateQ.cmdEn) begin
            stateD.wrEn = 1'b1;
        end else if (wrdiDone && stateQ.cmdEn) begin
            stateD.wrEn = 1'b0;
        end

        // APB read data and error are captured in the setup cycle.
        if (apbSetup) begin
            stateD.rdErr = 1'b0;
            stateD.rdata = '0;
            if (paddr == flash_prot_pkg::ADDR_STATUS) begin
                stateD.rdata = statusWord;
            end else if (paddr == flash_prot_pkg::ADDR_PROT) begin
                stateD.rdata = stateQ.prot;
            end else if (paddr == flash_prot_pkg::ADDR_CTRL) begin
                stateD.rdata[flash_prot_pkg::CTRL_EN_POS] = stateQ.cmdEn;
            end else begin
                stateD.rdErr = 1'b1;
            end
        end

        if (apbAccess && pwrite && (paddr == flash_prot_pkg::ADDR_CTRL)) begin
            stateD.cmdEn = pwdata[flash_prot_pkg::CTRL_EN_POS];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stateQ.prot    <= flash_prot_pkg::PROT_RESET;
            stateQ.lock    <= flash_prot_pkg::LOCK_RESET;
            stateQ.wrEn    <= flash_prot_pkg::WREN_RESET;
            stateQ.cmdEn   <= flash_prot_pkg::CTRL_EN_RESET;
            stateQ.outcome <= flash_prot_pkg::OUT_NONE;
            stateQ.rdata   <= '0;
            stateQ.rdErr   <= 1'b0;
        end else begin
            stateQ <= stateD;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign protBits          = stateQ.prot;
    assign protectionLockBit = stateQ.lock;
    assign writeEnableLatch  = stateQ.wrEn;
    assign prdata            = stateQ.rdata;
    assign pready            = 1'b1;
    assign pslverr           = apbAccess && stateQ.rdErr;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence unlockedWrite;
        wsrGo && !protectionLockBit;
    endsequence

    sequence hardLocked;
        wsrDone && protectionLockBit && !wpN;
    endsequence

    sequence softLocked;
        wsrGo && protectionLockBit && wpN;
    endsequence

    sequence mixedField;
        flash_prot_pkg::gpField(wsrData) != flash_prot_pkg::GP_ALL_SET &&
        flash_prot_pkg::gpField(wsrData) != flash_prot_pkg::GP_ALL_CLR;
    endsequence

    sequence statusSetup;
        apbSetup && paddr == flash_prot_pkg::ADDR_STATUS;
    endsequence

    sequence sectorProtect;
        secGo && sectorProtDone;
    endsequence

    sequence lockedSector;
        secSeen && protectionLockBit;
    endsequence

    sequence latchSetReq;
        wrenDone && !wsrDone && !sectorProtDone && !sectorUnprotDone && stateQ.cmdEn;
    endsequence

    sequence latchClearReq;
        wrdiDone && !wrenDone && !wsrDone && !sectorProtDone && !sectorUnprotDone;
    endsequence

    globalProtect_a: assert property (
        unlockedWrite and (flash_prot_pkg::gpField(wsrData) == flash_prot_pkg::GP_ALL_SET)
        |=> protBits == flash_prot_pkg::PROT_RESET)
        else $error("global protect did not set all sectors");

    globalUnprotect_a: assert property (
        unlockedWrite and (flash_prot_pkg::gpField(wsrData) == flash_prot_pkg::GP_ALL_CLR)
        |=> protBits == '0)
        else $error("global unprotect did not clear all sectors");

    mixedKeep_a: assert property (
        wsrGo and mixedField |=> $stable(protBits))
        else $error("mixed field changed sector protection");

    hardLock_a: assert property (
        hardLocked |=> protectionLockBit && $stable(protBits))
        else $error("hard lock did not hold");

    lockFollow_a: assert property (
        unlockedWrite |=> protectionLockBit == $past(wsrData[flash_prot_pkg::LOCK_POS]))
        else $error("lock bit did not follow data bit 7");

    sectorOnly_a: assert property (
        secGo && sectorUnprotDone |=>
        protBits == ($past(protBits) & ~(32'h1 << $past(sectorIdx))))
        else $error("sector unprotect touched other sectors");

    softLock_a: assert property (
        softLocked |=> $stable(protBits) && protectionLockBit == $past(wsrData[flash_prot_pkg::LOCK_POS]))
        else $error("soft lock handling wrong");

    latchGate_a: assert property (
        wsrDone && !writeEnableLatch |=> $stable(protBits) && $stable(protectionLockBit))
        else $error("status write ran without write enable");

    latchClear_a: assert property (
        wsrGo |=> !writeEnableLatch ##1 !writeEnableLatch || $past(wrenDone))
        else $error("write enable latch not cleared after status write");

    lockOnlyAtEnd_a: assert property (
        $changed(protectionLockBit) && !$past(sys_rst) |-> $past(wsrGo))
        else $error("lock bit changed outside a status write");

    fieldNotKept_a: assert property (
        statusSetup |=> prdata[flash_prot_pkg::ST_WP_POS] == $past(wpN) &&
        prdata[flash_prot_pkg::ST_LOCK_POS] == $past(protectionLockBit))
        else $error("written field bits leaked into status");

    // ------------------------------------------------------------
    // Sector command, latch and outcome assertions
    // ------------------------------------------------------------
    sectorProtect_a: assert property (
        sectorProtect |=>
        protBits == ($past(protBits) | (32'h1 << $past(sectorIdx))))
        else $error("sector protect touched other sectors");

    lockedSector_a: assert property (
        lockedSector |=> $stable(protBits) && !writeEnableLatch)
        else $error("sector command changed locked protection");

    sectorGate_a: assert property (
        secSeen && !writeEnableLatch |=> $stable(protBits))
        else $error("sector command ran without write enable");

    latchSet_a: assert property (
        latchSetReq |=> writeEnableLatch)
        else $error("write enable did not set the latch");

    latchDrop_a: assert property (
        latchClearReq |=> !writeEnableLatch)
        else $error("write disable did not clear the latch");

    discardKeep_a: assert property (
        wsrDrop |=> $stable(protBits) && $stable(protectionLockBit) && $stable(writeEnableLatch))
        else $error("discarded status write changed state");

    discardOutcome_a: assert property (
        wsrDrop |=> stateQ.outcome == flash_prot_pkg::OUT_DISCARDED)
        else $error("discarded status write not reported");

    lockedOutcome_a: assert property (
        wsrGo && protectionLockBit |=> stateQ.outcome == flash_prot_pkg::OUT_LOCKED)
        else $error("locked status write not reported");

    protectOutcome_a: assert property (
        unlockedWrite and (flash_prot_pkg::gpField(wsrData) == flash_prot_pkg::GP_ALL_SET)
        |=> stateQ.outcome == flash_prot_pkg::OUT_GLOBAL_PROTECT)
        else $error("global protect not reported");

    unprotectOutcome_a: assert property (
        unlockedWrite and (flash_prot_pkg::gpField(wsrData) == flash_prot_pkg::GP_ALL_CLR)
        |=> stateQ.outcome == flash_prot_pkg::OUT_GLOBAL_UNPROTECT)
        else $error("global unprotect not reported");

    mixedOutcome_a: assert property (
        unlockedWrite and mixedField |=> stateQ.outcome == flash_prot_pkg::OUT_NO_CHANGE)
        else $error("mixed field not reported as no change");

    lockHeld_a: assert property (
        protectionLockBit && !wpN |=> protectionLockBit)
        else $error("lock bit cleared while write protect is low");

    protSource_a: assert property (
        $changed(protBits) && !$past(sys_rst) |-> $past(wsrGo) || $past(secGo))
        else $error("sector protection changed outside a command");

    cmdOff_a: assert property (
        !stateQ.cmdEn |=> $stable(protBits) && $stable(protectionLockBit) && $stable(writeEnableLatch))
        else $error("command taken while commands are disabled");

endmodule

// ### pkg/flash_prot_pkg.sv
// Notes on behaviour
// - With locking allowing it, a status write whose bits 5..2 are all ones sets every sector protection bit.
// - With locking allowing it, a status write whose bits 5..2 are all zeros clears every sector protection bit.
// - A status write whose bits 5..2 are mixed leaves every sector protection bit as it was.
// - With the write-protect pin low and the lock bit set, global requests are ignored and the lock stays set.
// - With the lock bit clear, the new lock bit is written data bit 7, whatever happens to the sectors.
// - Global changes coexist with per-sector commands, which touch only their own sector afterwards.
// - With the write-protect pin high and the lock bit set, no global change occurs but a 0 in bit 7 clears the lock.
// - Written bits 5..2 are only decoded, never stored; only bit 7, the lock bit, is kept.
// - The write-status command runs only if the write enable latch was set before; otherwise it is dropped.
package flash_prot_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int SECTOR_COUNT = 32;
    localparam int SECTOR_IDX_W = 5;
    localparam int APB_ADDR_W   = 8;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_PROT   = 8'h04;
    localparam logic [7:0] ADDR_CTRL   = 8'h08;

    // ------------------------------------------------------------
    // Written status byte fields
    // ------------------------------------------------------------
    localparam int         LOCK_POS   = 7;
    localparam int         GP_HI      = 5;
    localparam int         GP_LO      = 2;
    localparam logic [3:0] GP_ALL_SET = 4'hf;
    localparam logic [3:0] GP_ALL_CLR = 4'h0;

    // ------------------------------------------------------------
    // Status and control register fields
    // ------------------------------------------------------------
    localparam int ST_WREN_POS = 1;
    localparam int ST_WP_POS   = 4;
    localparam int ST_LOCK_POS = 7;
    localparam int ST_OUT_LO   = 8;
    localparam int ST_OUT_HI   = 10;
    localparam int CTRL_EN_POS = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] PROT_RESET    = 32'hffffffff;
    localparam logic        LOCK_RESET    = 1'b0;
    localparam logic        WREN_RESET    = 1'b0;
    localparam logic        CTRL_EN_RESET = 1'b1;

    typedef enum logic [2:0] {
        OUT_NONE,
        OUT_GLOBAL_PROTECT,
        OUT_GLOBAL_UNPROTECT,
        OUT_NO_CHANGE,
        OUT_LOCKED,
        OUT_DISCARDED
    } outcome_t;

    function automatic logic [3:0] gpField(input logic [7:0] d);
        return d[GP_HI:GP_LO];
    endfunction

endpackage

// ### rtl/wsr_decode.sv
// ------------------------------------------------------------
// Decode of one written status byte
// ------------------------------------------------------------
module wsr_decode (
    input  wire logic [7:0]               data,
    input  wire logic                     lockCur,
    input  wire logic                     wpN,
    input  wire logic [31:0]              protCur,
    output logic [31:0]                   protNext,
    output logic                          lockNext,
    output flash_prot_pkg::outcome_t      outcome
);

    logic [3:0] gp;

    always_comb begin
        gp       = flash_prot_pkg::gpField(data);
        protNext = protCur;
        lockNext = lockCur;
        outcome  = flash_prot_pkg::OUT_NO_CHANGE;
        if (lockCur && !wpN) begin
            // Hard lock: sectors and lock bit both frozen.
            outcome = flash_prot_pkg::OUT_LOCKED;
        end else if (lockCur) begin
            // Soft lock: only the lock bit may move.
            lockNext = data[flash_prot_pkg::LOCK_POS];
            outcome  = flash_prot_pkg::OUT_LOCKED;
        end else begin
            lockNext = data[flash_prot_pkg::LOCK_POS];
            if (gp == flash_prot_pkg::GP_ALL_SET) begin
                protNext = flash_prot_pkg::PROT_RESET;
                outcome  = flash_prot_pkg::OUT_GLOBAL_PROTECT;
            end else if (gp == flash_prot_pkg::GP_ALL_CLR) begin
                protNext = '0;
                outcome  = flash_prot_pkg::OUT_GLOBAL_UNPROTECT;
            end else begin
                outcome  = flash_prot_pkg::OUT_NO_CHANGE;
            end
        end
    end

endmodule

// ### verification/flash_host_model.sv
// ------------------------------------------------------------
// Host side: issues whole commands as chip-select-end pulses.
// ------------------------------------------------------------
module flash_host_model (
    input  wire logic       clk,
    output logic            wsrDone,
    output logic            wsrByteOk,
    output logic [7:0]      wsrData,
    output logic            wrenDone,
    output logic            wrdiDone,
    output logic            sectorProtDone,
    output logic            sectorUnprotDone,
    output logic [4:0]      sectorIdx
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        {wsrDone, wsrByteOk, wrenDone, wrdiDone, sectorProtDone, sectorUnprotDone} = 6'h00;
        wsrData   = 8'h00;
        sectorIdx = 5'h00;
    end

    // Kind 0 status write, 1 write enable, 2 write disable, 3 sector protect, 4 sector unprotect.
    task automatic send(input int kind, input logic [7:0] data, input logic ok, input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        wsrData   <= data;
        wsrByteOk <= ok;
        sectorIdx <= data[4:0];
        wsrDone          <= (kind == 0);
        wrenDone         <= (kind == 1);
        wrdiDone         <= (kind == 2);
        sectorProtDone   <= (kind == 3);
        sectorUnprotDone <= (kind == 4);
        @(posedge clk);
        {wsrDone, wrenDone, wrdiDone, sectorProtDone, sectorUnprotDone} <= 5'h00;
        wsrData <= ~data;
    endtask
endmodule

// ### verification/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        int          kind;
        logic        wp;
        logic [7:0]  data;
        logic [31:0] prot;
        logic        lock;
    } row_t;

    logic        clk;
    logic        sys_rst;
    logic        wpN;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] protBits;
    logic        protectionLockBit;
    logic        writeEnableLatch;
    logic        wsrDone, wsrByteOk, wrenDone, wrdiDone, sectorProtDone, sectorUnprotDone;
    logic [7:0]  wsrData;
    logic [4:0]  sectorIdx;
    logic [31:0] rd;
    logic        er;
    int          err_count;
    int          samples_checked;
    int          cycles = 0;
    row_t        rows[13] = '{
        '{0, 1, 8'h00, 32'h00000000, 0}, '{3, 1, 8'h03, 32'h00000008, 0}, '{0, 1, 8'h04, 32'h00000008, 0},
        '{0, 1, 8'h38, 32'h00000008, 0}, '{0, 1, 8'h7f, 32'hffffffff, 0}, '{4, 1, 8'h1f, 32'h7fffffff, 0},
        '{0, 1, 8'hf0, 32'h7fffffff, 1}, '{0, 1, 8'h00, 32'h7fffffff, 0}, '{0, 0, 8'hbc, 32'hffffffff, 1},
        '{0, 0, 8'h00, 32'hffffffff, 1}, '{4, 0, 8'h00, 32'hffffffff, 1}, '{0, 1, 8'h43, 32'hffffffff, 0},
        '{0, 0, 8'h83, 32'h00000000, 1}};

    flash_host_model i_host (.clk(clk), .wsrDone(wsrDone), .wsrByteOk(wsrByteOk), .wsrData(wsrData),
        .wrenDone(wrenDone), .wrdiDone(wrdiDone), .sectorProtDone(sectorProtDone),
        .sectorUnprotDone(sectorUnprotDone), .sectorIdx(sectorIdx));

    global_sector_protect_decode i_dut (.clk(clk), .sys_rst(sys_rst), .wsrDone(wsrDone),
        .wsrByteOk(wsrByteOk), .wsrData(wsrData), .wrenDone(wrenDone), .wrdiDone(wrdiDone),
        .sectorProtDone(sectorProtDone), .sectorUnprotDone(sectorUnprotDone), .sectorIdx(sectorIdx),
        .wpN(wpN), .protBits(protBits), .protectionLockBit(protectionLockBit),
        .writeEnableLatch(writeEnableLatch), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cmd(input int kind, input logic [7:0] data, input logic ok);
        i_host.send(kind, data, ok, 0);
        #1;
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic state(input logic [31:0] prot, input logic lock, input logic latch);
        chk("protBits", protBits, prot);
        chk("lock", {31'h0, protectionLockBit}, {31'h0, lock});
        chk("latch", {31'h0, writeEnableLatch}, {31'h0, latch});
    endtask

    task automatic checkOutcome(input flash_prot_pkg::outcome_t exp);
        apb(1'b0, flash_prot_pkg::ADDR_STATUS, 32'h0);
        chk("outcome", {29'h0, rd[flash_prot_pkg::ST_OUT_HI:flash_prot_pkg::ST_OUT_LO]}, {29'h0, exp});
    endtask

    initial begin
        err_count = 0;
        samples_checked = 0;
        {sys_rst, wpN, psel, penable, pwrite} = 5'b11000;
        paddr  = 8'h00;
        pwdata = 32'h0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        state(32'hffffffff, 1'b0, 1'b0);
        foreach (rows[i]) begin
            @(posedge clk);
            wpN <= rows[i].wp;
            cmd(1, 8'h00, 1'b1);
            cmd(rows[i].kind, rows[i].data, 1'b1);
            state(rows[i].prot, rows[i].lock, 1'b0);
        end
        checkOutcome(flash_prot_pkg::OUT_GLOBAL_UNPROTECT);
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        wpN     <= 1'b1;
        @(posedge clk);
        #1;
        state(32'hffffffff, 1'b0, 1'b0);
        cmd(0, 8'h00, 1'b1);
        state(32'hffffffff, 1'b0, 1'b0);
        cmd(1, 8'h00, 1'b1);
        cmd(2, 8'h00, 1'b1);
        cmd(0, 8'h80, 1'b1);
        state(32'hffffffff, 1'b0, 1'b0);
        cmd(1, 8'h00, 1'b1);
        cmd(0, 8'h80, 1'b0);
        state(32'hffffffff, 1'b0, 1'b1);
        cmd(0, 8'h00, 1'b1);
        state(32'h00000000, 1'b0, 1'b0);
        apb(1'b1, 8'h04, 32'hffffffff);
        apb(1'b0, 8'h04, 32'h0);
        chk("prot read", rd, 32'h00000000);
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped err", {31'h0, er}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b1, 8'h08, 32'h0);
        cmd(1, 8'h00, 1'b1);
        cmd(0, 8'h3c, 1'b1);
        state(32'h00000000, 1'b0, 1'b0);
        checkOutcome(flash_prot_pkg::OUT_DISCARDED);
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b0, 8'h08, 32'h0);
        chk("ctrl read", rd, 32'h1);
        cmd(1, 8'h00, 1'b1);
        cmd(0, 8'h3c, 1'b1);
        state(32'hffffffff, 1'b0, 1'b0);
        apb(1'b0, 8'h00, 32'h0);
        chk("status low byte", {24'h0, rd[7:0]}, 32'h10);
        checkOutcome(flash_prot_pkg::OUT_GLOBAL_PROTECT);
        stop_test();
    end
endmodule
